/* File: design/esq_defines.svh */
/*
 * Constants for the enable/reset and recovery sequencer: timing figures,
 * derived cycle counts, configuration field positions and reset values.
 * Assumes a 50 MHz system clock; included by bare name.
 */
`ifndef ESQ_DEFINES_SVH
`define ESQ_DEFINES_SVH

`define ESQ_CLK_PERIOD_NS 20
// least low time of the enable pin, in microseconds
`define ESQ_T_OE_LOW_US 100
// least time rounds up
`define ESQ_OE_LOW_CYC ((`ESQ_T_OE_LOW_US * 1000 + `ESQ_CLK_PERIOD_NS - 1) / `ESQ_CLK_PERIOD_NS)
// longest recovery-on latency, in milliseconds
`define ESQ_T_REC_ON_MS 15
// longest time rounds down
`define ESQ_REC_ON_CYC ((`ESQ_T_REC_ON_MS * 1000000) / `ESQ_CLK_PERIOD_NS)
// longest recovery-off latency, in nanoseconds
`define ESQ_T_REC_OFF_NS 120
`define ESQ_REC_OFF_CYC ((`ESQ_T_REC_OFF_NS) / `ESQ_CLK_PERIOD_NS)

`define ESQ_CFG_W 8
`define ESQ_CFG_RESET 8'h00
`define ESQ_CFG_RETIMER_BIT 0
`define ESQ_CNT_W 20

`endif

/* File: design/esq_pkg.sv */
/*
 * Types shared by the sequencer modules.
 * Assumes esq_defines.svh holds the widths.
 */
`include "esq_defines.svh"

package esq_pkg;
    typedef enum logic [1:0] {
        REC_OFF,
        REC_ACQUIRE,
        REC_ON
    } esq_rec_e;

    typedef logic [`ESQ_CFG_W-1:0] esq_cfg_t;
    typedef logic [`ESQ_CNT_W-1:0] esq_cnt_t;
endpackage

/* File: design/esq_sync_if.sv */
/*
 * Carrier between the top and the pin synchroniser: raw pin level in,
 * clean level out. Assumes one clock domain on the sync side.
 */
`timescale 1ns/10ps

interface esq_sync_if;
    logic raw;
    logic synced;
    modport sink (input raw, output synced);
    modport user (output raw, input synced);
endinterface

/* File: design/esq_sync.sv */
/*
 * Two-flop synchroniser for one asynchronous pin, frozen by the clock
 * enable. Assumes the pin level is quasi-static relative to CLK.
 */
`timescale 1ns/10ps

module esq_sync (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // pin side and clean side
    esq_sync_if.sink port
);
    logic meta;
    logic stable;

    // the first stage feeds only the second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= 1'b0;
            stable <= 1'b0;
        end else if (ce) begin
            meta <= port.raw;
            stable <= meta;
        end
    end

    assign port.synced = stable;
endmodule

/* File: design/esq_top.sv */
/*
 * Enable/reset sequencer with clock-data-recovery start and stop timing.
 * Assumes OE arrives straight from a pin or capacitor, while the config
 * write strobe and retimer request come from logic on CLK.
 */
// Behaviour
// R1: while the enable is low every control input is ignored.
// R2: while the enable is low the receive and transmit link pins float.
// R3: the controller holds the enable low at least 100 us for a proper reset.
// R4: a low pulse of at least the minimum length fully resets internal state.
// R5: reset drops written configuration, which the controller must rewrite.
// R6: the controller raises the enable only once the core supply is good.
// R7: normal operation starts only after the enable goes high.
// R8: recovery is running at most 15 ms after retimer mode is entered.
// R9: recovery stops at most 120 ns after retimer mode is left.
// R10: the controller keeps both supplies stable 100 us before pulling enable low.
// R11: the enable is synchronised and config is held at default while it is low.
`timescale 1ns/10ps
`include "esq_defines.svh"

module esq_top #(
    parameter int OE_LOW_CYC = `ESQ_OE_LOW_CYC,
    parameter int REC_ON_CYC = `ESQ_REC_ON_CYC
) (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    // enable pin
    input wire logic OE,
    // control inputs
    input wire logic CFG_WE,
    input wire logic [`ESQ_CFG_W-1:0] CFG_WDATA,
    input wire logic RETIMER_REQ,
    // status
    output logic DEV_ACTIVE,
    output logic [`ESQ_CFG_W-1:0] CFG_Q,
    output logic RESET_DONE,
    output logic SHORT_LOW,
    output logic CDR_ACTIVE,
    // link pin enables, low while driving
    output logic LINK_RX_OE_N,
    output logic LINK_TX_OE_N
);
    localparam int OFF_CYC = `ESQ_REC_OFF_CYC;

    esq_sync_if oe_if ();
    logic oe_on;
    logic oe_was;
    logic oe_rise;
    esq_pkg::esq_cnt_t low_cnt;
    logic low_long;
    logic retimer;
    esq_pkg::esq_rec_e rec_state;
    esq_pkg::esq_rec_e next_rec_state;
    esq_pkg::esq_cnt_t acq_cnt;

    assign oe_if.raw = OE;

    // R11 pin synchroniser
    esq_sync u_oe_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .ce(CE),
        .port(oe_if)
    );

    assign oe_on = oe_if.synced;
    assign oe_rise = oe_on && !oe_was;
    assign low_long = (low_cnt >= esq_pkg::esq_cnt_t'(OE_LOW_CYC));

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            oe_was <= 1'b0;
        end else if (CE) begin
            oe_was <= oe_on;
        end
    end

    // R4 low-time meter, saturating so a long hold never wraps
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            low_cnt <= '0;
        end else if (CE) begin
            if (oe_on) begin
                low_cnt <= '0;
            end else if (!low_long) begin
                low_cnt <= low_cnt + 1'b1;
            end
        end
    end

    // R4 release marks a full reset or a too-short pulse
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESET_DONE <= 1'b0;
            SHORT_LOW <= 1'b0;
        end else if (CE) begin
            RESET_DONE <= oe_rise && low_long;
            if (oe_rise) begin
                SHORT_LOW <= !low_long;
            end
        end
    end

    // R7 active only once the enable has risen
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DEV_ACTIVE <= 1'b0;
        end else if (CE) begin
            DEV_ACTIVE <= oe_on;
        end
    end

    // R2 link pins float while disabled
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            LINK_RX_OE_N <= 1'b1;
            LINK_TX_OE_N <= 1'b1;
        end else if (CE) begin
            LINK_RX_OE_N <= !oe_on;
            LINK_TX_OE_N <= !oe_on;
        end
    end

    // R5 R11 config held at default while low, writes only while enabled
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CFG_Q <= `ESQ_CFG_RESET;
        end else if (CE) begin
            if (!oe_on) begin
                CFG_Q <= `ESQ_CFG_RESET;
            end else if (CFG_WE && DEV_ACTIVE) begin
                CFG_Q <= CFG_WDATA;
            end
        end
    end

    // R1 retimer request gated by the enable
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            retimer <= 1'b0;
        end else if (CE) begin
            retimer <= oe_on && DEV_ACTIVE && RETIMER_REQ
                && CFG_Q[`ESQ_CFG_RETIMER_BIT];
        end
    end

    // R8 R9 recovery sequencing; leaving retimer mode wins at once
    always_comb begin
        next_rec_state = rec_state;
        case (rec_state)
            esq_pkg::REC_OFF: begin
                if (retimer) begin
                    next_rec_state = esq_pkg::REC_ACQUIRE;
                end
            end
            esq_pkg::REC_ACQUIRE: begin
                if (!retimer) begin
                    next_rec_state = esq_pkg::REC_OFF;
                // request flop, state entry and output flop take three edges
                end else if (acq_cnt >= esq_pkg::esq_cnt_t'(REC_ON_CYC - 3)) begin
                    next_rec_state = esq_pkg::REC_ON;
                end
            end
            esq_pkg::REC_ON: begin
                if (!retimer) begin
                    next_rec_state = esq_pkg::REC_OFF;
                end
            end
            default: begin
                next_rec_state = esq_pkg::REC_OFF;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rec_state <= esq_pkg::REC_OFF;
        end else if (CE) begin
            rec_state <= next_rec_state;
        end
    end

    // acquisition counter only runs while acquiring
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acq_cnt <= '0;
        end else if (CE) begin
            if (rec_state == esq_pkg::REC_ACQUIRE) begin
                acq_cnt <= acq_cnt + 1'b1;
            end else begin
                acq_cnt <= '0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CDR_ACTIVE <= 1'b0;
        end else if (CE) begin
            // enable low stops recovery at once, not one retimer flop later
            CDR_ACTIVE <= oe_on && (next_rec_state == esq_pkg::REC_ON);
        end
    end

    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // R2 float while disabled
    chk_link_float: assert property (CE && !oe_on |=> LINK_RX_OE_N && LINK_TX_OE_N) // R2
        else $error("link pins driven while disabled");

    // R1 no write lands while disabled
    chk_cfg_ignored: assert property (CE && !oe_on |=> CFG_Q == `ESQ_CFG_RESET) // R1
        else $error("config changed while disabled");

    // R11 default value while low
    chk_cfg_default: assert property (!DEV_ACTIVE && CE |=> CFG_Q == `ESQ_CFG_RESET) // R11
        else $error("config not at default while inactive");

    // R7 activity follows the enable
    chk_active_follow: assert property (CE && oe_rise |=> DEV_ACTIVE) // R7
        else $error("device not active after enable rise");

    // R7 inactive before rise
    chk_inactive_low: assert property (CE && !oe_on |=> !DEV_ACTIVE && !CDR_ACTIVE) // R7
        else $error("device active while enable low");

    // R4 long pulse gives full reset
    chk_full_reset: assert property (CE && oe_rise && low_long |=> RESET_DONE && !SHORT_LOW) // R4
        else $error("long low pulse did not reset");

    // R5 rewrite needed after reset
    chk_cfg_dropped: assert property (RESET_DONE |-> CFG_Q == `ESQ_CFG_RESET) // R5
        else $error("config survived reset");

    // R9 off within the latency
    chk_rec_off: assert property (!retimer && CE |=> !CDR_ACTIVE) // R9
        else $error("recovery still on after retimer exit");

    // R9 bound stays within the printed figure
    chk_off_bound: assert property ($fell(retimer) |-> ##[1:OFF_CYC] !CDR_ACTIVE) // R9
        else $error("recovery off later than allowed");

    // R8 on never before mode is entered
    chk_rec_cause: assert property ($rose(CDR_ACTIVE) |-> $past(retimer)) // R8
        else $error("recovery on without retimer mode");

    // R8 acquisition never outlasts the bound
    chk_acq_bound: assert property (rec_state == esq_pkg::REC_ACQUIRE
        |-> acq_cnt < esq_pkg::esq_cnt_t'(REC_ON_CYC)) // R8
        else $error("recovery acquisition too long");

    cov_full_reset: cover property (RESET_DONE);
    cov_short_pulse: cover property ($rose(SHORT_LOW));
    cov_rec_on: cover property ($rose(CDR_ACTIVE));
    cov_rec_off: cover property ($fell(CDR_ACTIVE));
endmodule

/* File: verif/esq_ctrl_model.sv */
/*
 * Controller model that drives the enable pin of the sequencer.
 * Assumes the bench asks for each low pulse with its length in cycles.
 */
`timescale 1ns/10ps

module esq_ctrl_model #(
    parameter int STABLE_CYC = 5
) (
    // clock and supply state
    input wire logic clk,
    input wire logic supply_ok,
    // pulse request
    input wire logic go,
    input wire logic [31:0] low_len,
    // enable pin
    output logic oe,
    output logic busy
);
    int stable;
    int left;

    initial begin
        oe = 1'b0;
        busy = 1'b0;
        stable = 0;
        left = 0;
    end

    always @(posedge clk) begin
        stable <= supply_ok ? stable + 1 : 0;
    end

    always @(posedge clk) begin
        if (busy && left <= 1 && supply_ok) begin
            oe <= 1'b1;
            busy <= 1'b0;
        end else if (busy) begin
            left <= left - 1;
        end else if (go && stable >= STABLE_CYC) begin
            oe <= 1'b0;
            left <= low_len;
            busy <= 1'b1;
        end
    end
endmodule

/* File: verif/enable_reset_cdr_sequencer_tb.sv */
/*
 * Self-checking bench for the enable/reset sequencer.
 * Assumes a small low-time and recovery count set through parameters.
 */
`timescale 1ns/10ps

module enable_reset_cdr_sequencer_tb;
    localparam int ON_CYC = 10;
    logic clk, reset_n, oe, go, busy, cfg_we, retimer_req;
    logic dev_active, reset_done, short_low, cdr_active, rx_oe_n, tx_oe_n;
    logic [7:0] cfg_wdata, cfg_q;
    int err_total, n_checks, low_len, n;

    esq_top #(.OE_LOW_CYC(8), .REC_ON_CYC(ON_CYC)) esq_top_inst (
        .CLK(clk), .RESET_N(reset_n), .CE(1'b1), .OE(oe),
        .CFG_WE(cfg_we), .CFG_WDATA(cfg_wdata), .RETIMER_REQ(retimer_req),
        .DEV_ACTIVE(dev_active), .CFG_Q(cfg_q), .RESET_DONE(reset_done),
        .SHORT_LOW(short_low), .CDR_ACTIVE(cdr_active),
        .LINK_RX_OE_N(rx_oe_n), .LINK_TX_OE_N(tx_oe_n)
    );

    esq_ctrl_model esq_ctrl_model_inst (
        .clk(clk), .supply_ok(1'b1), .go(go), .low_len(low_len), .oe(oe), .busy(busy)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        cfg_we = 1'b1;
        cfg_wdata = d;
        @(negedge clk);
        cfg_we = 1'b0;
    endtask

    // low pulse on the pin, then judge the rise
    task automatic pulse(input int len, input logic exp_done);
        logic done_seen;
        done_seen = 1'b0;
        low_len = len;
        @(negedge clk);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (int i = 0; i < len + 4 && busy; i++) @(negedge clk);
        for (int i = 0; i < 6 && dev_active !== 1'b1; i++) begin
            @(negedge clk);
            done_seen = done_seen | reset_done;
        end
        check("dev_active", dev_active, 8'h01);
        check("reset_done", done_seen, exp_done);
        check("short_low", short_low, !exp_done);
        check("link_oe_n", {rx_oe_n, tx_oe_n}, 8'h00);
    endtask

    task automatic test_idle();
        repeat (4) @(negedge clk);
        check("dev_active", dev_active, 8'h00);
        check("link_oe_n", {rx_oe_n, tx_oe_n}, 8'h03);
        wr(8'h5A);
        check("cfg_q", cfg_q, 8'h00);
        pulse(12, 1'b1);
        $display("test idle done");
    endtask

    task automatic test_config_low();
        wr(8'hA5);
        check("cfg_q", cfg_q, 8'hA5);
        wr(8'h01);
        fork
            pulse(30, 1'b1);
            begin
                repeat (10) @(negedge clk);
                wr(8'hFF);
                retimer_req = 1'b1;
                repeat (6) @(negedge clk);
                check("link_oe_n", {rx_oe_n, tx_oe_n}, 8'h03);
                check("cfg_q", cfg_q, 8'h00);
                check("cdr_active", cdr_active, 8'h00);
            end
        join
        retimer_req = 1'b0;
        check("cfg_q", cfg_q, 8'h00);
        $display("test config_low done");
    endtask

    task automatic test_short();
        wr(8'h01);
        pulse(3, 1'b0);
        check("cfg_q", cfg_q, 8'h00);
        pulse(8, 1'b1);
        $display("test short done");
    endtask

    task automatic test_cdr();
        wr(8'h01);
        retimer_req = 1'b1;
        n = 0;
        for (int i = 0; i < 3 * ON_CYC && cdr_active !== 1'b1; i++) begin
            @(negedge clk);
            n++;
        end
        check("cdr_on_in_time", 8'(n >= 1 && n <= ON_CYC), 8'h01);
        retimer_req = 1'b0;
        n = 0;
        for (int i = 0; i < 20 && cdr_active !== 1'b0; i++) begin
            @(negedge clk);
            n++;
        end
        check("cdr_off_in_time", 8'(n <= 6), 8'h01);
        $display("test cdr done");
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial begin
        reset_n = 1'b0;
        go = 1'b0;
        low_len = 0;
        cfg_we = 1'b0;
        cfg_wdata = 8'h00;
        retimer_req = 1'b0;
        err_total = 0;
        n_checks = 0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        test_idle();
        test_config_low();
        test_short();
        test_cdr();
        stop_test();
    end
endmodule
